// >>> geidc_pkg.sv
/*
  Package for the external pin interrupt and debug pin configuration block:
  register offsets, field positions, reset values, trigger modes, timing
  constants and the packed bus request carrier.
  Assumes a 32-bit classic Wishbone bus with byte addresses on 16 bits.
*/
package geidc_pkg;

  // ---------------------------------------------------------------------
  // Register offsets (byte addresses)
  // ---------------------------------------------------------------------
  localparam logic [15:0] OFS_PENDING    = 16'hA814;
  localparam logic [15:0] OFS_IRQ_MASK   = 16'hA818;
  localparam logic [15:0] OFS_CFG_A      = 16'hA860;
  localparam logic [15:0] OFS_CFG_B      = 16'hA864;
  localparam logic [15:0] OFS_CFG_C      = 16'hA868;
  localparam logic [15:0] OFS_CFG_D      = 16'hA86C;
  localparam logic [15:0] OFS_DBG_CFG    = 16'hBC00;
  localparam logic [15:0] OFS_DBG_STAT   = 16'hBC04;
  localparam logic [15:0] OFS_SEL_C      = 16'hBC14;
  localparam logic [15:0] OFS_SEL_D      = 16'hBC18;

  // ---------------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------------
  localparam int          NUM_LINES      = 4;
  localparam int          NUM_PINS       = 24;
  localparam int          SEL_MSB        = 4;
  localparam int          FILT_BIT       = 8;
  localparam int          MODE_LSB       = 5;
  localparam int          MODE_MSB       = 7;
  localparam int          DBG_DIS_BIT    = 5;
  localparam int          REG_DIS_BIT    = 4;
  localparam int          DBG_HW_BIT     = 3;
  localparam int          STAT_BOOT_BIT  = 3;
  localparam int          STAT_FORCE_BIT = 1;
  localparam int          STAT_SWEN_BIT  = 0;
  localparam logic [4:0]  SEL_C_RST      = 5'h0F;
  localparam logic [4:0]  SEL_D_RST      = 5'h10;
  localparam logic [4:0]  SEL_FIRST_RSVD = 5'h18;
  localparam logic        REG_DIS_RST    = 1'h1;
  localparam logic [31:0] ZERO_WORD      = 32'h0000_0000;

  // ---------------------------------------------------------------------
  // Timing: input filter needs the pin stable for this long
  // ---------------------------------------------------------------------
  localparam int          CLK_HZ         = 10_000_000;
  localparam int          FILT_TIME_NS   = 300;
  localparam int          FILT_CYCLES    =
    (FILT_TIME_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam logic [2:0]  FILT_LAST      = 3'(FILT_CYCLES - 1);
  localparam logic [1:0]  BOOT_WAIT      = 2'h2;

  // ---------------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------------
  typedef enum logic [2:0] {
    TRIG_OFF   = 3'b000,
    TRIG_RISE  = 3'b001,
    TRIG_FALL  = 3'b010,
    TRIG_BOTH  = 3'b011,
    TRIG_HIGH  = 3'b100,
    TRIG_LOW   = 3'b101
  } geidc_trig_t;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [15:0] adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } geidc_wb_req_t;

  typedef struct packed {
    logic        filt;
    logic [2:0]  mode;
  } geidc_line_cfg_t;

endpackage

// >>> geidc_top.sv
/*
  External pin interrupt lines A to D with trigger modes, input filter,
  pin routing for lines C and D, pending flags with masked interrupt, and
  the debug pin configuration and status registers, on classic Wishbone.
  Assumes pins, boot strap and debugger status arrive asynchronously.
*/
// Design decision made here: register access over Wishbone.

// Summary of operation
// - Five bit selector routes lines C, D
// - Selector codes 0x18-0x1F pick no pin
// - Selectors reset to 0x0F and 0x10
// - Bit 8 enables input digital filter
// - Mode 0 off, 1 rise, 2 fall, 3 both
// - Mode 4 high level, 5 low level
// - Pending flags D..A in bits 3..0
// - Pending flags read zero after reset
// - Bit 5 disables debug unless already active
// - Bit 4 disables regulator override, resets one
// - Status bit 3 captures inverted boot pin
// - Status bit 1 shows debugger forced active
// - Status bit 0 shows serial wire enabled
module geidc_top (
  input  wire logic        I_CLK,
  input  wire logic        I_RST_B,
  input  wire logic        I_WB_CYC,
  input  wire logic        I_WB_STB,
  input  wire logic        I_WB_WE,
  input  wire logic [15:0] I_WB_ADR,
  input  wire logic [3:0]  I_WB_SEL,
  input  wire logic [31:0] I_WB_DAT,
  output logic      [31:0] O_WB_DAT,
  output logic             O_WB_ACK,
  input  wire logic        I_EXT_LINE_A,
  input  wire logic        I_EXT_LINE_B,
  input  wire logic [7:0]  I_PORT_A,
  input  wire logic [7:0]  I_PORT_B,
  input  wire logic [7:0]  I_PORT_C,
  input  wire logic        I_BOOT_SELECT_PIN_N,
  input  wire logic        I_DEBUGGER_FORCED_ACTIVE,
  input  wire logic        I_SERIAL_WIRE_ENABLED,
  input  wire logic        I_DEBUG_HW_STATE,
  output logic             O_IRQ,
  output logic             O_DEBUG_OVERRIDE_DISABLE,
  output logic             O_REGULATOR_OVERRIDE_DISABLE
);

  localparam int SYNC_W = geidc_pkg::NUM_PINS + 6;

  // -----------------------------------------------------------------------
  // Functions
  // -----------------------------------------------------------------------
  function automatic logic [31:0] byte_mask(input logic [3:0] sel);
    logic [31:0] m;
    m = geidc_pkg::ZERO_WORD;
    for (int b = 0; b < 4; b++) begin
      m[b*8 +: 8] = {8{sel[b]}};
    end
    return m;
  endfunction

  function automatic logic pin_pick(input logic [23:0] pins,
                                    input logic [4:0]  sel);
    logic r;
    r = 1'b0;
    if (sel < geidc_pkg::SEL_FIRST_RSVD) begin
      r = pins[sel];
    end
    return r;
  endfunction

  // -----------------------------------------------------------------------
  // Input synchronisers
  // -----------------------------------------------------------------------
  logic [SYNC_W-1:0] sync_raw;
  logic [SYNC_W-1:0] sync1_ff;
  logic [SYNC_W-1:0] sync2_ff;
  logic [23:0]       pins_s;
  logic              line_a_s;
  logic              line_b_s;
  logic              boot_n_s;
  logic              forced_s;
  logic              swen_s;
  logic              hw_bit_s;

  assign sync_raw = {I_DEBUG_HW_STATE, I_SERIAL_WIRE_ENABLED,
                     I_DEBUGGER_FORCED_ACTIVE, I_BOOT_SELECT_PIN_N,
                     I_EXT_LINE_B, I_EXT_LINE_A,
                     I_PORT_C, I_PORT_B, I_PORT_A};

  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      sync1_ff <= '0;
      sync2_ff <= '0;
    end else begin
      sync1_ff <= sync_raw;
      sync2_ff <= sync1_ff;
    end
  end

  assign pins_s   = sync2_ff[23:0];
  assign line_a_s = sync2_ff[24];
  assign line_b_s = sync2_ff[25];
  assign boot_n_s = sync2_ff[26];
  assign forced_s = sync2_ff[27];
  assign swen_s   = sync2_ff[28];
  assign hw_bit_s = sync2_ff[29];

  // -----------------------------------------------------------------------
  // Bus slave
  // -----------------------------------------------------------------------
  geidc_pkg::geidc_wb_req_t req;
  logic        ack_ff;
  logic        nxt_ack;
  logic [31:0] rdat_ff;
  logic [31:0] nxt_rdat;
  logic        wr_go;
  logic [31:0] wmask;
  logic [31:0] wdat;

  assign req   = '{cyc: I_WB_CYC, stb: I_WB_STB, we: I_WB_WE,
                   adr: I_WB_ADR, sel: I_WB_SEL, dat: I_WB_DAT};
  assign wr_go = req.cyc & req.stb & req.we & ack_ff;
  assign wmask = byte_mask(req.sel);
  assign wdat  = req.dat & wmask;

  // -----------------------------------------------------------------------
  // Register state
  // -----------------------------------------------------------------------
  geidc_pkg::geidc_line_cfg_t cfg_ff  [geidc_pkg::NUM_LINES];
  geidc_pkg::geidc_line_cfg_t nxt_cfg [geidc_pkg::NUM_LINES];
  logic [4:0]  sel_c_ff;
  logic [4:0]  nxt_sel_c;
  logic [4:0]  sel_d_ff;
  logic [4:0]  nxt_sel_d;
  logic [3:0]  mask_ff;
  logic [3:0]  nxt_mask;
  logic [3:0]  pend_ff;
  logic [3:0]  nxt_pend;
  logic [3:0]  trig;
  logic        dbg_dis_ff;
  logic        nxt_dbg_dis;
  logic        reg_dis_ff;
  logic        nxt_reg_dis;
  logic        boot_cap_ff;
  logic        nxt_boot_cap;
  logic [1:0]  boot_cnt_ff;
  logic [1:0]  nxt_boot_cnt;
  logic [31:0] cfg_word [geidc_pkg::NUM_LINES];
  logic [15:0] cfg_ofs  [geidc_pkg::NUM_LINES];

  assign cfg_ofs[0] = geidc_pkg::OFS_CFG_A;
  assign cfg_ofs[1] = geidc_pkg::OFS_CFG_B;
  assign cfg_ofs[2] = geidc_pkg::OFS_CFG_C;
  assign cfg_ofs[3] = geidc_pkg::OFS_CFG_D;

  // -----------------------------------------------------------------------
  // Register next state
  // -----------------------------------------------------------------------
  always_comb begin
    logic [15:0] a;
    a            = {req.adr[15:2], 2'b00};
    nxt_sel_c    = sel_c_ff;
    nxt_sel_d    = sel_d_ff;
    nxt_mask     = mask_ff;
    nxt_dbg_dis  = dbg_dis_ff;
    nxt_reg_dis  = reg_dis_ff;
    nxt_pend     = pend_ff;
    for (int i = 0; i < geidc_pkg::NUM_LINES; i++) begin
      nxt_cfg[i] = cfg_ff[i];
    end
    if (wr_go) begin
      if (a == geidc_pkg::OFS_SEL_C) begin
        if (req.sel[0]) begin
          nxt_sel_c = req.dat[geidc_pkg::SEL_MSB:0];
        end
      end else if (a == geidc_pkg::OFS_SEL_D) begin
        if (req.sel[0]) begin
          nxt_sel_d = req.dat[geidc_pkg::SEL_MSB:0];
        end
      end else if (a == geidc_pkg::OFS_IRQ_MASK) begin
        if (req.sel[0]) begin
          nxt_mask = req.dat[3:0];
        end
      end else if (a == geidc_pkg::OFS_PENDING) begin
        nxt_pend = pend_ff & ~wdat[3:0];
      end else if (a == geidc_pkg::OFS_DBG_CFG) begin
        if (req.sel[0]) begin
          nxt_dbg_dis = req.dat[geidc_pkg::DBG_DIS_BIT];
          nxt_reg_dis = req.dat[geidc_pkg::REG_DIS_BIT];
        end
      end
      for (int i = 0; i < geidc_pkg::NUM_LINES; i++) begin
        if (a == cfg_ofs[i]) begin
          if (req.sel[1]) begin
            nxt_cfg[i].filt = req.dat[geidc_pkg::FILT_BIT];
          end
          if (req.sel[0]) begin
            nxt_cfg[i].mode =
              req.dat[geidc_pkg::MODE_MSB:geidc_pkg::MODE_LSB];
          end
        end
      end
    end
    nxt_pend = nxt_pend | trig;
  end

  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      sel_c_ff   <= geidc_pkg::SEL_C_RST;
      sel_d_ff   <= geidc_pkg::SEL_D_RST;
      mask_ff    <= '0;
      pend_ff    <= '0;
      dbg_dis_ff <= 1'b0;
      reg_dis_ff <= geidc_pkg::REG_DIS_RST;
      for (int i = 0; i < geidc_pkg::NUM_LINES; i++) begin
        cfg_ff[i] <= '0;
      end
    end else begin
      sel_c_ff   <= nxt_sel_c;
      sel_d_ff   <= nxt_sel_d;
      mask_ff    <= nxt_mask;
      pend_ff    <= nxt_pend;
      dbg_dis_ff <= nxt_dbg_dis;
      reg_dis_ff <= nxt_reg_dis;
      for (int i = 0; i < geidc_pkg::NUM_LINES; i++) begin
        cfg_ff[i] <= nxt_cfg[i];
      end
    end
  end

  // -----------------------------------------------------------------------
  // Boot strap capture after reset release
  // -----------------------------------------------------------------------
  always_comb begin
    nxt_boot_cnt = boot_cnt_ff;
    nxt_boot_cap = boot_cap_ff;
    // Synchroniser shows its reset level for two edges after release,
    // so the strap is taken one edge later, once the pin has come through
    if (boot_cnt_ff <= geidc_pkg::BOOT_WAIT) begin
      nxt_boot_cnt = boot_cnt_ff + 2'h1;
      if (boot_cnt_ff == geidc_pkg::BOOT_WAIT) begin
        nxt_boot_cap = ~boot_n_s;
      end
    end
  end

  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      boot_cnt_ff <= '0;
      boot_cap_ff <= 1'b0;
    end else begin
      boot_cnt_ff <= nxt_boot_cnt;
      boot_cap_ff <= nxt_boot_cap;
    end
  end

  // -----------------------------------------------------------------------
  // Per line filter and trigger detection
  // -----------------------------------------------------------------------
  logic [3:0] line_raw;

  assign line_raw[0] = line_a_s;
  assign line_raw[1] = line_b_s;
  assign line_raw[2] = pin_pick(pins_s, sel_c_ff);
  assign line_raw[3] = pin_pick(pins_s, sel_d_ff);

  generate
    for (genvar g = 0; g < geidc_pkg::NUM_LINES; g++) begin : g_line
      logic [2:0] cnt_ff;
      logic [2:0] nxt_cnt;
      logic       fval_ff;
      logic       nxt_fval;
      logic       prev_ff;
      logic       cur;
      geidc_pkg::geidc_trig_t mode;

      assign mode = geidc_pkg::geidc_trig_t'(cfg_ff[g].mode);
      assign cur  = cfg_ff[g].filt ? fval_ff : line_raw[g];

      always_comb begin
        nxt_cnt  = '0;
        nxt_fval = fval_ff;
        if (line_raw[g] != fval_ff) begin
          nxt_cnt = cnt_ff + 3'h1;
          if (cnt_ff == geidc_pkg::FILT_LAST) begin
            nxt_fval = line_raw[g];
            nxt_cnt  = '0;
          end
        end
        case (mode)
          geidc_pkg::TRIG_RISE: trig[g] = cur & ~prev_ff;
          geidc_pkg::TRIG_FALL: trig[g] = ~cur & prev_ff;
          geidc_pkg::TRIG_BOTH: trig[g] = cur ^ prev_ff;
          geidc_pkg::TRIG_HIGH: trig[g] = cur;
          geidc_pkg::TRIG_LOW:  trig[g] = ~cur;
          default:              trig[g] = 1'b0;
        endcase
      end

      always_ff @(posedge I_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
          cnt_ff  <= '0;
          fval_ff <= 1'b0;
          prev_ff <= 1'b0;
        end else begin
          cnt_ff  <= nxt_cnt;
          fval_ff <= nxt_fval;
          prev_ff <= cur;
        end
      end

      assign cfg_word[g] = {23'h000000, cfg_ff[g].filt, cfg_ff[g].mode,
                            5'h00};
    end
  endgenerate

  // -----------------------------------------------------------------------
  // Read data and acknowledge
  // -----------------------------------------------------------------------
  always_comb begin
    logic [15:0] a;
    a        = {req.adr[15:2], 2'b00};
    nxt_ack  = req.cyc & req.stb & ~ack_ff;
    nxt_rdat = geidc_pkg::ZERO_WORD;
    if (a == geidc_pkg::OFS_PENDING) begin
      nxt_rdat[3:0] = pend_ff;
    end else if (a == geidc_pkg::OFS_IRQ_MASK) begin
      nxt_rdat[3:0] = mask_ff;
    end else if (a == geidc_pkg::OFS_CFG_A) begin
      nxt_rdat = cfg_word[0];
    end else if (a == geidc_pkg::OFS_CFG_B) begin
      nxt_rdat = cfg_word[1];
    end else if (a == geidc_pkg::OFS_CFG_C) begin
      nxt_rdat = cfg_word[2];
    end else if (a == geidc_pkg::OFS_CFG_D) begin
      nxt_rdat = cfg_word[3];
    end else if (a == geidc_pkg::OFS_SEL_C) begin
      nxt_rdat[4:0] = sel_c_ff;
    end else if (a == geidc_pkg::OFS_SEL_D) begin
      nxt_rdat[4:0] = sel_d_ff;
    end else if (a == geidc_pkg::OFS_DBG_CFG) begin
      nxt_rdat[geidc_pkg::DBG_DIS_BIT] = dbg_dis_ff;
      nxt_rdat[geidc_pkg::REG_DIS_BIT] = reg_dis_ff;
      nxt_rdat[geidc_pkg::DBG_HW_BIT]  = hw_bit_s;
    end else if (a == geidc_pkg::OFS_DBG_STAT) begin
      nxt_rdat[geidc_pkg::STAT_BOOT_BIT]  = boot_cap_ff;
      nxt_rdat[geidc_pkg::STAT_FORCE_BIT] = forced_s;
      nxt_rdat[geidc_pkg::STAT_SWEN_BIT]  = swen_s;
    end
    if (!nxt_ack) begin
      nxt_rdat = rdat_ff;
    end
  end

  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      ack_ff  <= 1'b0;
      rdat_ff <= '0;
    end else begin
      ack_ff  <= nxt_ack;
      rdat_ff <= nxt_rdat;
    end
  end

  // -----------------------------------------------------------------------
  // Outputs
  // -----------------------------------------------------------------------
  assign O_WB_ACK = ack_ff;
  assign O_WB_DAT = rdat_ff;
  assign O_IRQ    = |(pend_ff & mask_ff);
  assign O_DEBUG_OVERRIDE_DISABLE =
    dbg_dis_ff & ~(forced_s | swen_s);
  assign O_REGULATOR_OVERRIDE_DISABLE = reg_dis_ff;

endmodule // geidc_top

// >>> geidc_monitor.sv
/*
  Checker of the external interrupt and debug configuration block.
  Sees only top module ports; bound into every geidc_top instance.
*/
module geidc_monitor (
  input wire logic        I_CLK,
  input wire logic        I_RST_B,
  input wire logic        I_WB_CYC,
  input wire logic        I_WB_STB,
  input wire logic        I_WB_WE,
  input wire logic [15:0] I_WB_ADR,
  input wire logic [3:0]  I_WB_SEL,
  input wire logic [31:0] I_WB_DAT,
  input wire logic [31:0] O_WB_DAT,
  input wire logic        O_WB_ACK,
  input wire logic        I_DEBUGGER_FORCED_ACTIVE,
  input wire logic        I_SERIAL_WIRE_ENABLED,
  input wire logic        O_IRQ,
  input wire logic        O_DEBUG_OVERRIDE_DISABLE,
  input wire logic        O_REGULATOR_OVERRIDE_DISABLE
);
  timeunit 1ns;
  timeprecision 1ns;
  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  wire logic req     = I_WB_CYC && I_WB_STB;
  wire logic stat_rd = O_WB_ACK && req && !I_WB_WE &&
                       I_WB_ADR == geidc_pkg::OFS_DBG_STAT;
  wire logic cfg_wr  = O_WB_ACK && req && I_WB_WE && I_WB_SEL[0] &&
                       I_WB_ADR == geidc_pkg::OFS_DBG_CFG;
  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (!I_RST_B);
  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  a_ack_pulse: assert property (O_WB_ACK |=> !O_WB_ACK)
    else $error("ack longer than one cycle");
  a_ack_answer: assert property (req && !O_WB_ACK |=> O_WB_ACK)
    else $error("request not answered next cycle");
  a_ack_cause: assert property (!req |=> !O_WB_ACK)
    else $error("ack without request");
  a_rdata_hold: assert property (!O_WB_ACK |-> $stable(O_WB_DAT))
    else $error("read data moved without ack");
  a_regdis_reset: assert property (
    $rose(I_RST_B) |-> O_REGULATOR_OVERRIDE_DISABLE)
    else $error("regulator override disable not set after reset");
  a_irq_reset: assert property ($rose(I_RST_B) |-> !O_IRQ)
    else $error("interrupt high after reset");
  a_regdis_write: assert property (
    cfg_wr |=> O_REGULATOR_OVERRIDE_DISABLE ==
      $past(I_WB_DAT[geidc_pkg::REG_DIS_BIT]))
    else $error("regulator override disable not written");
  a_dbg_active: assert property (
    (I_DEBUGGER_FORCED_ACTIVE || I_SERIAL_WIRE_ENABLED) [*4]
    |-> !O_DEBUG_OVERRIDE_DISABLE)
    else $error("debug disabled while already active");
  a_swen_status: assert property (
    $stable(I_SERIAL_WIRE_ENABLED) [*5] ##0 stat_rd
    |-> O_WB_DAT[0] == I_SERIAL_WIRE_ENABLED)
    else $error("serial wire status bit wrong");
  a_forced_status: assert property (
    $stable(I_DEBUGGER_FORCED_ACTIVE) [*5] ##0 stat_rd
    |-> O_WB_DAT[1] == I_DEBUGGER_FORCED_ACTIVE)
    else $error("forced debug status bit wrong");
  c_cfg_write: cover property (cfg_wr);
  c_irq_rise: cover property ($rose(O_IRQ));
  c_dbg_dis: cover property ($rose(O_DEBUG_OVERRIDE_DISABLE));
endmodule // geidc_monitor

bind geidc_top geidc_monitor geidc_monitor_inst (
  .I_CLK(I_CLK), .I_RST_B(I_RST_B), .I_WB_CYC(I_WB_CYC),
  .I_WB_STB(I_WB_STB), .I_WB_WE(I_WB_WE), .I_WB_ADR(I_WB_ADR),
  .I_WB_SEL(I_WB_SEL), .I_WB_DAT(I_WB_DAT), .O_WB_DAT(O_WB_DAT),
  .O_WB_ACK(O_WB_ACK), .O_IRQ(O_IRQ),
  .I_DEBUGGER_FORCED_ACTIVE(I_DEBUGGER_FORCED_ACTIVE),
  .I_SERIAL_WIRE_ENABLED(I_SERIAL_WIRE_ENABLED),
  .O_DEBUG_OVERRIDE_DISABLE(O_DEBUG_OVERRIDE_DISABLE),
  .O_REGULATOR_OVERRIDE_DISABLE(O_REGULATOR_OVERRIDE_DISABLE)
);

// >>> geidc_pin_model.sv
/*
  Model of the port pins, strap pin and debugger cable status.
  Levels requested by the bench change just after a clock edge.
*/
module geidc_pin_model (
  input  wire logic        i_clk,
  input  wire logic [23:0] i_ports,
  input  wire logic [1:0]  i_lines,
  input  wire logic [3:0]  i_dbg,
  output logic      [7:0]  o_port_a,
  output logic      [7:0]  o_port_b,
  output logic      [7:0]  o_port_c,
  output logic             o_line_a,
  output logic             o_line_b,
  output logic             o_boot_n,
  output logic             o_forced,
  output logic             o_swen,
  output logic             o_hw
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [29:0] pins_ff = {4'h1, 26'h0};
  always_ff @(posedge i_clk) begin
    pins_ff <= {i_dbg, i_lines, i_ports};
  end
  assign {o_hw, o_swen, o_forced, o_boot_n, o_line_b, o_line_a,
          o_port_c, o_port_b, o_port_a} = pins_ff;
endmodule // geidc_pin_model

// >>> geidc_tb.sv
/*
  Self-checking bench of the external interrupt and debug block.
  Assumes geidc_top, geidc_pkg, the pin model and the checker.
*/
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk, rst_b, cyc, stb, we;
  logic [15:0] adr;
  logic [3:0]  sel;
  logic [31:0] wdat;
  logic [23:0] cmd_ports;
  logic [1:0]  cmd_lines;
  logic [3:0]  cmd_dbg;
  wire logic [31:0] rdat;
  wire logic [7:0]  pa, pb, pc;
  wire logic        ack, irq, dbg_dis, reg_dis;
  wire logic        la, lb, boot_n, forced, swen, hw;
  int               num_errors, n_tests;

  geidc_pin_model geidc_pin_model_inst (.i_clk(clk), .i_ports(cmd_ports),
    .i_lines(cmd_lines), .i_dbg(cmd_dbg), .o_port_a(pa), .o_port_b(pb),
    .o_port_c(pc), .o_line_a(la), .o_line_b(lb), .o_boot_n(boot_n),
    .o_forced(forced), .o_swen(swen), .o_hw(hw));
  geidc_top geidc_top_inst (.I_CLK(clk), .I_RST_B(rst_b), .I_WB_CYC(cyc),
    .I_WB_STB(stb), .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_SEL(sel),
    .I_WB_DAT(wdat), .O_WB_DAT(rdat), .O_WB_ACK(ack), .I_EXT_LINE_A(la),
    .I_EXT_LINE_B(lb), .I_PORT_A(pa), .I_PORT_B(pb), .I_PORT_C(pc),
    .I_BOOT_SELECT_PIN_N(boot_n), .I_DEBUGGER_FORCED_ACTIVE(forced),
    .I_SERIAL_WIRE_ENABLED(swen), .I_DEBUG_HW_STATE(hw), .O_IRQ(irq),
    .O_DEBUG_OVERRIDE_DISABLE(dbg_dis),
    .O_REGULATOR_OVERRIDE_DISABLE(reg_dis));

  always #50 clk = ~clk;

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic idle(input int k);
    repeat (k) @(posedge clk);
  endtask
  task automatic check(input string nm, input logic [31:0] s, e);
    n_tests++;
    if (s !== e) begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wb(input logic w, input logic [15:0] a,
                    input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hF;
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask
  task automatic rd(input string nm, input logic [15:0] a,
                    input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    check(nm, q, e);
  endtask
  task automatic summarize;
    if (num_errors == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset;
    logic [15:0] ra [11] = '{16'hA814, 16'hA818, 16'hA860, 16'hA864,
      16'hA868, 16'hA86C, 16'hBC00, 16'hBC04, 16'hBC14, 16'hBC18, 16'h0};
    logic [31:0] ex [11] = '{0, 0, 0, 0, 0, 0, 32'h10, 0, 32'hF, 32'h10, 0};
    for (int i = 0; i < 11; i++) rd("reset_value", ra[i], ex[i]);
  endtask
  task automatic t_sel(input int ln);
    logic [15:0] sa;
    sa = (ln == 2) ? geidc_pkg::OFS_SEL_C : geidc_pkg::OFS_SEL_D;
    wr(16'(geidc_pkg::OFS_CFG_A + 4 * ln), 32'h20);
    for (int c = 0; c < 32; c++) begin
      wr(sa, 32'(c));
      rd("sel_readback", sa, 32'(c));
      wr(geidc_pkg::OFS_PENDING, 32'hF);
      cmd_ports <= (c < 24) ? 24'h1 << c : 24'hFFFFFF;
      idle(6);
      rd("sel_hit", 16'hA814, (c < 24) ? 32'h1 << ln : 32'h0);
      cmd_ports <= 24'h0;
      idle(6);
    end
    wr(16'(geidc_pkg::OFS_CFG_A + 4 * ln), 32'h0);
  endtask
  task automatic t_modes;
    for (int m = 0; m < 8; m++) begin
      wr(geidc_pkg::OFS_CFG_A, 32'(m) << 5);
      idle(4);
      wr(geidc_pkg::OFS_PENDING, 32'h1);
      rd("low_level", 16'hA814, 32'(m == 5));
      cmd_lines[0] <= 1'b1;
      idle(6);
      rd("rise", 16'hA814, 32'(m == 1 || m == 3 || m > 3 && m < 6));
      wr(geidc_pkg::OFS_PENDING, 32'h1);
      rd("high_level", 16'hA814, 32'(m == 4));
      cmd_lines[0] <= 1'b0;
      idle(6);
      rd("fall", 16'hA814, 32'(m > 1 && m < 6));
    end
    wr(geidc_pkg::OFS_CFG_A, 32'h0);
  endtask
  task automatic t_filter;
    wr(geidc_pkg::OFS_CFG_B, 32'h120);
    wr(geidc_pkg::OFS_PENDING, 32'h2);
    cmd_lines[1] <= 1'b1;
    idle(2);
    cmd_lines[1] <= 1'b0;
    idle(8);
    rd("filter_glitch", 16'hA814, 32'h0);
    cmd_lines[1] <= 1'b1;
    idle(8);
    rd("filter_pass", 16'hA814, 32'h2);
    check("irq_masked", 32'(irq), 32'h0);
    wr(geidc_pkg::OFS_IRQ_MASK, 32'h2);
    idle(1);
    check("irq_on", 32'(irq), 32'h1);
    wr(geidc_pkg::OFS_PENDING, 32'h2);
    idle(1);
    check("irq_cleared", 32'(irq), 32'h0);
    wr(geidc_pkg::OFS_CFG_B, 32'h20);
    cmd_lines[1] <= 1'b0;
    idle(6);
    cmd_lines[1] <= 1'b1;
    idle(1);
    cmd_lines[1] <= 1'b0;
    idle(8);
    rd("unfiltered_pulse", 16'hA814, 32'h2);
    wr(geidc_pkg::OFS_PENDING, 32'h2);
    wr(geidc_pkg::OFS_CFG_B, 32'h0);
  endtask
  task automatic t_debug;
    logic [31:0] q;
    cmd_dbg <= 4'h9;
    idle(4);
    wb(1'b0, geidc_pkg::OFS_DBG_CFG, 32'h0, q);
    check("dbg_cfg", q, 32'h18);
    wr(geidc_pkg::OFS_DBG_CFG, (q & ~32'h10) | 32'h20);
    idle(5);
    check("regulator_disable", 32'(reg_dis), 32'h0);
    check("debug_disable", 32'(dbg_dis), 32'h1);
    cmd_dbg <= 4'h3;
    idle(5);
    check("debug_forced", 32'(dbg_dis), 32'h0);
    rd("forced_status", geidc_pkg::OFS_DBG_STAT, 32'h2);
    cmd_dbg <= 4'h5;
    idle(5);
    rd("swen_status", geidc_pkg::OFS_DBG_STAT, 32'h1);
    check("debug_swen", 32'(dbg_dis), 32'h0);
    cmd_dbg <= 4'h1;
    idle(5);
    check("debug_idle", 32'(dbg_dis), 32'h1);
    rd("dbg_cfg_back", geidc_pkg::OFS_DBG_CFG, 32'h20);
  endtask
  task automatic t_boot;
    cmd_dbg <= 4'h0;
    idle(2);
    rst_b <= 1'b0;
    idle(4);
    rst_b <= 1'b1;
    idle(4);
    rd("boot_captured", geidc_pkg::OFS_DBG_STAT, 32'h8);
    rd("regulator_reset", geidc_pkg::OFS_DBG_CFG, 32'h10);
    rd("sel_c_reset", geidc_pkg::OFS_SEL_C, 32'hF);
  endtask

  initial begin
    clk = 1'b0;
    rst_b = 1'b0;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 16'h0;
    sel = 4'h0;
    wdat = 32'h0;
    cmd_ports = 24'h0;
    cmd_lines = 2'h0;
    cmd_dbg = 4'h1;
    num_errors = 0;
    n_tests = 0;
    idle(4);
    rst_b <= 1'b1;
    t_reset();
    t_sel(2);
    t_sel(3);
    t_modes();
    t_filter();
    t_debug();
    t_boot();
    summarize();
  end
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    summarize();
  end
endmodule // testbench
